// ==== rtl/ebw_ctrl.sv ====
// External bus unit: register slave, window pick and multiplexed bus cycle
//
// Design decisions made here: the AXI4-Lite slave port and the register offsets.
`timescale 1ns/1ps
`include "ebw_defs.svh"
module ebw_ctrl (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] s_awaddr,
    input wire logic s_awvalid,
    output logic s_awready,
    input wire logic [31:0] s_wdata,
    input wire logic [3:0] s_wstrb,
    input wire logic s_wvalid,
    output logic s_wready,
    output logic [1:0] s_bresp,
    output logic s_bvalid,
    input wire logic s_bready,
    input wire logic [7:0] s_araddr,
    input wire logic s_arvalid,
    output logic s_arready,
    output logic [31:0] s_rdata,
    output logic [1:0] s_rresp,
    output logic s_rvalid,
    input wire logic s_rready,
    input wire logic cpu_req,
    input wire ebw_pkg::ebw_req_t cpu_cmd,
    output logic cpu_ack,
    output logic cpu_err,
    output logic [15:0] cpu_rdata,
    input wire logic [15:0] port_i,
    output logic [15:0] port_o,
    output logic [15:0] port_oe,
    output logic ale,
    output logic rd_n,
    output logic wr_n,
    output logic bhe_n,
    output logic serial_pins_free,
    output logic on_chip_extension_bus_enable,
    output logic on_chip_extension_bus_sel
);
    logic [15:0] sys_cfg;
    logic [15:0] def_cfg;
    logic [`EBW_NWIN*16-1:0] win_cfg;
    logic [`EBW_NWIN*16-1:0] win_sel;
    ebw_pkg::ebw_state_t st;
    ebw_pkg::ebw_cfg_t cur;
    ebw_pkg::ebw_req_t req;
    logic second;
    logic [2:0] last_win;
    logic last_err;
    logic cnt_load;
    logic [3:0] cnt_val;
    logic cnt_zero;

    // Register write decode
    wire [5:0] widx = s_awaddr[7:2];
    wire wr_go = s_awvalid & s_wvalid & ~s_awready & ~s_bvalid;
    wire w_sys = wr_go & (widx == `EBW_OFF_SYSCFG);
    wire w_def = wr_go & (widx == `EBW_OFF_DEFCFG);
    wire w_ok = (widx <= `EBW_OFF_STATUS);
    wire [15:0] strb_mask = {{8{s_wstrb[1]}}, {8{s_wstrb[0]}}};

    // Register read decode
    wire [5:0] ridx = s_araddr[7:2];
    wire rd_go = s_arvalid & ~s_arready & ~s_rvalid;
    wire r_ok = (ridx <= `EBW_OFF_STATUS);
    wire busy = (st != ebw_pkg::S_IDLE);
    wire [15:0] status = {busy, 11'h000, last_win, last_err};
    wire [5:0] rw_off = ridx - `EBW_OFF_WCFG;
    wire [5:0] rs_off = ridx - `EBW_OFF_WSEL;
    wire [15:0] r_mux =
        (ridx == `EBW_OFF_SYSCFG) ? sys_cfg :
        (ridx == `EBW_OFF_DEFCFG) ? def_cfg :
        (ridx < `EBW_OFF_WSEL) ? win_cfg[rw_off[1:0]*16 +: 16] :
        (ridx < `EBW_OFF_STATUS) ? win_sel[rs_off[1:0]*16 +: 16] :
        (ridx == `EBW_OFF_STATUS) ? status : 16'h0000;

    // Mode and enable fields
    wire [1:0] mode_raw = sys_cfg[`EBW_SYS_MODE_MSB:`EBW_SYS_MODE_LSB];
    wire ebw_pkg::ebw_mode_t mode = ebw_pkg::ebw_mode_t'(mode_raw);
    wire is16 = (mode == ebw_pkg::EBW_MUX16);
    wire is8 = (mode == ebw_pkg::EBW_MUX8);
    wire ext_periph_enable_bit = sys_cfg[`EBW_SYS_EXT_PERIPH_ENABLE_BIT_BIT];

    // Merge byte lanes of a register write
    function automatic logic [15:0] merge(input logic [15:0] old,
                                          input logic [15:0] nw,
                                          input logic [15:0] m);
        merge = (old & ~m) | (nw & m);
    endfunction

    // AXI write channel handshake and response
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_awready <= 1'b0;
            s_wready <= 1'b0;
            s_bvalid <= 1'b0;
            s_bresp <= `EBW_RESP_OKAY;
        end else begin
            s_awready <= wr_go;
            s_wready <= wr_go;
            if (wr_go) begin
                s_bvalid <= 1'b1;
                s_bresp <= w_ok ? `EBW_RESP_OKAY : `EBW_RESP_SLVERR;
            end else if (s_bready) begin
                s_bvalid <= 1'b0;
            end
        end
    end

    // AXI read channel handshake and data
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_arready <= 1'b0;
            s_rvalid <= 1'b0;
            s_rdata <= 32'h0000_0000;
            s_rresp <= `EBW_RESP_OKAY;
        end else begin
            s_arready <= rd_go;
            if (rd_go) begin
                s_rvalid <= 1'b1;
                s_rdata <= {16'h0000, r_mux};
                s_rresp <= r_ok ? `EBW_RESP_OKAY : `EBW_RESP_SLVERR;
            end else if (s_rready) begin
                s_rvalid <= 1'b0;
            end
        end
    end

    // System and default configuration registers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sys_cfg <= `EBW_SYSCFG_RST;
            def_cfg <= `EBW_DEFCFG_RST;
        end else begin
            if (w_sys) begin
                sys_cfg <= merge(sys_cfg, s_wdata[15:0], strb_mask);
            end
            if (w_def) begin
                def_cfg <= merge(def_cfg, s_wdata[15:0], strb_mask);
            end
        end
    end

    // Window register pairs, one of each per window
    genvar gi;
    generate
        for (gi = 0; gi < `EBW_NWIN; gi = gi + 1) begin : g_reg
            wire wc = wr_go & (widx == `EBW_OFF_WCFG + 6'(gi));
            wire ws = wr_go & (widx == `EBW_OFF_WSEL + 6'(gi));
            always_ff @(posedge aclk) begin
                if (!aresetn) begin
                    win_cfg[gi*16 +: 16] <= `EBW_WCFG_RST;
                    win_sel[gi*16 +: 16] <= `EBW_WSEL_RST;
                end else begin
                    if (wc) begin
                        win_cfg[gi*16 +: 16] <= merge(win_cfg[gi*16 +: 16],
                            s_wdata[15:0], strb_mask);
                    end
                    if (ws) begin
                        win_sel[gi*16 +: 16] <= merge(win_sel[gi*16 +: 16],
                            s_wdata[15:0], strb_mask);
                    end
                end
            end
        end
    endgenerate

    // Window pick for the incoming request
    ebw_pkg::ebw_cfg_t pick_cfg;
    logic [2:0] pick_win;
    ebw_win_match u_match (
        .addr(cpu_cmd.addr),
        .sel_flat(win_sel),
        .cfg_flat(win_cfg),
        .def_cfg(def_cfg),
        .cfg(pick_cfg),
        .win(pick_win)
    );

    // Phase timer
    ebw_cnt u_cnt (
        .aclk(aclk),
        .aresetn(aresetn),
        .load(cnt_load),
        .value(cnt_val),
        .zero(cnt_zero)
    );

    // Request classification
    // The ack cycle ignores the request that the core still holds
    wire start = (st == ebw_pkg::S_IDLE) & cpu_req & ~cpu_ack;
    wire off_ext = (cpu_cmd.addr[`EBW_EXT_TOP_MSB:`EBW_EXT_TOP_LSB] != 8'h00);
    wire no_ext = ~(is16 | is8);
    wire in_on_chip_extension_bus = ext_periph_enable_bit &
        (cpu_cmd.addr[`EBW_EXT_TOP_MSB:8] == `EBW_ON_CHIP_EXTENSION_BUS_PAGE);
    wire go_ext = start & ~no_ext & ~off_ext & ~in_on_chip_extension_bus;

    // Lane masks for the address and data phases
    wire [15:0] a_mask = is8 ? `EBW_MASK_A11 : `EBW_MASK_ALL;
    wire hi_lane = is16 & (req.word | req.addr[0]);
    wire lo_lane = is8 | req.word | ~req.addr[0];
    wire [15:0] d_mask = is8 ? `EBW_MASK_D8 :
        {{8{hi_lane}}, {8{lo_lane}}};
    wire [7:0] w_byte = (second | (is16 & req.addr[0])) ?
        req.wdata[15:8] : req.wdata[7:0];
    wire [15:0] d_out = is16 ? (req.word ? req.wdata : {w_byte, w_byte})
                             : {8'h00, w_byte};
    wire [7:0] r_byte = (is16 & req.addr[0]) ? port_i[15:8] : port_i[7:0];
    wire [15:0] a_out = {req.addr[15:1], req.addr[0] | second};

    // Phase timer loads at each phase entry
    always_comb begin
        cnt_load = 1'b0;
        cnt_val = 4'h0;
        case (st)
            ebw_pkg::S_IDLE: begin
                cnt_load = go_ext;
                cnt_val = {3'b000, pick_cfg.ale_long};
            end
            ebw_pkg::S_ADDR: begin
                cnt_load = cnt_zero;
                cnt_val = cur.wait_len;
            end
            ebw_pkg::S_DLY: begin
                // Delay cycle must not eat into the memory cycle length
                cnt_load = 1'b1;
                cnt_val = cur.wait_len;
            end
            ebw_pkg::S_STRB: begin
                cnt_load = cnt_zero;
                cnt_val = {2'b00, cur.tri_len};
            end
            ebw_pkg::S_TRI: begin
                // Second byte pass needs its own latch strobe length
                cnt_load = cnt_zero & ~second;
                cnt_val = {3'b000, cur.ale_long};
            end
            default: begin
                cnt_load = 1'b0;
                cnt_val = 4'h0;
            end
        endcase
    end

    // Bus cycle sequencer
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st <= ebw_pkg::S_IDLE;
            cur <= ebw_pkg::ebw_cfg_t'(9'h000);
            req <= ebw_pkg::ebw_req_t'(42'h0);
            second <= 1'b0;
            port_o <= `EBW_MASK_NONE;
            port_oe <= `EBW_MASK_NONE;
            ale <= 1'b0;
            rd_n <= 1'b1;
            wr_n <= 1'b1;
            bhe_n <= 1'b1;
            cpu_ack <= 1'b0;
            cpu_err <= 1'b0;
            cpu_rdata <= 16'h0000;
            last_win <= 3'h0;
            last_err <= 1'b0;
            on_chip_extension_bus_sel <= 1'b0;
        end else begin
            cpu_ack <= 1'b0;
            on_chip_extension_bus_sel <= 1'b0;
            case (st)
                ebw_pkg::S_IDLE: begin
                    if (go_ext) begin
                        // Address phase on the shared port
                        st <= ebw_pkg::S_ADDR;
                        cur <= pick_cfg;
                        req <= cpu_cmd;
                        second <= 1'b0;
                        last_win <= pick_win;
                        port_o <= cpu_cmd.addr[15:0] & a_mask;
                        port_oe <= a_mask;
                        ale <= 1'b1;
                        bhe_n <= ~(is16 & (cpu_cmd.word | cpu_cmd.addr[0]));
                    end else if (start) begin
                        // No external cycle: single chip, out of range or
                        // an enabled extension peripheral
                        st <= ebw_pkg::S_DONE;
                        cpu_err <= no_ext | off_ext;
                        last_err <= no_ext | off_ext;
                        on_chip_extension_bus_sel <= in_on_chip_extension_bus & ~no_ext;
                        cpu_rdata <= 16'h0000;
                    end
                end
                ebw_pkg::S_ADDR: begin
                    if (cnt_zero) begin
                        // Address stays valid until the strobe falls
                        ale <= 1'b0;
                        st <= cur.rw_delay ? ebw_pkg::S_DLY
                                           : ebw_pkg::S_STRB;
                        // Same pins now carry data, or float for a read
                        port_o <= req.we ? d_out : `EBW_MASK_NONE;
                        port_oe <= req.we ? d_mask : `EBW_MASK_NONE;
                        rd_n <= cur.rw_delay | req.we;
                        wr_n <= cur.rw_delay | ~req.we;
                    end
                end
                ebw_pkg::S_DLY: begin
                    st <= ebw_pkg::S_STRB;
                    rd_n <= req.we;
                    wr_n <= ~req.we;
                end
                ebw_pkg::S_STRB: begin
                    if (cnt_zero) begin
                        // End of memory cycle: sample and release the bus
                        st <= ebw_pkg::S_TRI;
                        rd_n <= 1'b1;
                        wr_n <= 1'b1;
                        port_oe <= `EBW_MASK_NONE;
                        if (!req.we) begin
                            if (is16 & req.word) begin
                                cpu_rdata <= port_i;
                            end else if (second) begin
                                cpu_rdata[15:8] <= port_i[7:0];
                            end else begin
                                cpu_rdata <= {8'h00, r_byte};
                            end
                        end
                    end
                end
                ebw_pkg::S_TRI: begin
                    if (cnt_zero) begin
                        if (is8 & req.word & ~second) begin
                            // Word on the 8-bit bus: high byte next
                            second <= 1'b1;
                            st <= ebw_pkg::S_ADDR;
                            port_o <= {req.addr[15:1], 1'b1} & a_mask;
                            port_oe <= a_mask;
                            ale <= 1'b1;
                        end else begin
                            st <= ebw_pkg::S_DONE;
                            cpu_err <= 1'b0;
                            last_err <= 1'b0;
                            bhe_n <= 1'b1;
                        end
                    end
                end
                ebw_pkg::S_DONE: begin
                    cpu_ack <= 1'b1;
                    st <= ebw_pkg::S_IDLE;
                end
                default: begin
                    st <= ebw_pkg::S_IDLE;
                end
            endcase
        end
    end

    // Pin sharing and extension bus enable flags
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            serial_pins_free <= 1'b1;
            on_chip_extension_bus_enable <= 1'b0;
        end else begin
            serial_pins_free <= ~is16;
            on_chip_extension_bus_enable <= ext_periph_enable_bit;
        end
    end

    wire unused_a = a_out[0];
endmodule

// ==== rtl/ebw_defs.svh ====
// Offsets, field positions, reset values and lane masks of the bus unit
`ifndef EBW_DEFS_SVH
`define EBW_DEFS_SVH
`define EBW_OFF_SYSCFG 6'h00
`define EBW_OFF_DEFCFG 6'h01
`define EBW_OFF_WCFG 6'h02
`define EBW_OFF_WSEL 6'h06
`define EBW_OFF_STATUS 6'h0a
`define EBW_NWIN 4
`define EBW_SYS_MODE_MSB 1
`define EBW_SYS_MODE_LSB 0
`define EBW_SYS_EXT_PERIPH_ENABLE_BIT_BIT 2
`define EBW_SYSCFG_RST 16'h0000
`define EBW_DEFCFG_RST 16'h00ff
`define EBW_WCFG_RST 16'h0000
`define EBW_WSEL_RST 16'h0000
`define EBW_CFG_WAIT_MSB 3
`define EBW_CFG_WAIT_LSB 0
`define EBW_CFG_TRI_MSB 5
`define EBW_CFG_TRI_LSB 4
`define EBW_CFG_ALE_BIT 6
`define EBW_CFG_DLY_BIT 7
`define EBW_CFG_EN_BIT 8
`define EBW_SEL_BASE_MSB 15
`define EBW_SEL_BASE_LSB 4
`define EBW_SEL_SIZE_MSB 3
`define EBW_SEL_SIZE_LSB 0
`define EBW_PAGE_MSB 23
`define EBW_PAGE_LSB 12
`define EBW_EXT_TOP_MSB 23
`define EBW_EXT_TOP_LSB 16
`define EBW_ON_CHIP_EXTENSION_BUS_PAGE 16'h00ef
`define EBW_MASK_ALL 16'hffff
`define EBW_MASK_A11 16'h07ff
`define EBW_MASK_D8 16'h00ff
`define EBW_MASK_NONE 16'h0000
`define EBW_RESP_OKAY 2'b00
`define EBW_RESP_SLVERR 2'b10
`endif

// ==== rtl/ebw_pkg.sv ====
// Types shared by the external bus unit files
package ebw_pkg;
    typedef enum logic [1:0] {
        EBW_SINGLE = 2'b00,
        EBW_MUX16 = 2'b01,
        EBW_MUX8 = 2'b10,
        EBW_RSVD = 2'b11
    } ebw_mode_t;
    typedef enum logic [2:0] {
        S_IDLE = 3'b000,
        S_ADDR = 3'b001,
        S_DLY = 3'b010,
        S_STRB = 3'b011,
        S_TRI = 3'b100,
        S_DONE = 3'b101
    } ebw_state_t;
    typedef struct packed {
        logic en;
        logic rw_delay;
        logic ale_long;
        logic [1:0] tri_len;
        logic [3:0] wait_len;
    } ebw_cfg_t;
    typedef struct packed {
        logic [23:0] addr;
        logic we;
        logic word;
        logic [15:0] wdata;
    } ebw_req_t;
endpackage

// ==== rtl/ebw_cnt.sv ====
// Down counter that times each phase of an external bus cycle
`timescale 1ns/1ps
module ebw_cnt (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic load,
    input wire logic [3:0] value,
    output logic zero
);
    logic [3:0] cnt;

    // Load wins; otherwise count down and rest at zero
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cnt <= 4'h0;
        end else if (load) begin
            cnt <= value;
        end else if (cnt != 4'h0) begin
            cnt <= cnt - 4'h1;
        end
    end

    assign zero = (cnt == 4'h0);
endmodule

// ==== rtl/ebw_win_match.sv ====
// Address window compare and priority pick of the bus characteristics
`timescale 1ns/1ps
`include "ebw_defs.svh"
module ebw_win_match (
    input wire logic [23:0] addr,
    input wire logic [`EBW_NWIN*16-1:0] sel_flat,
    input wire logic [`EBW_NWIN*16-1:0] cfg_flat,
    input wire logic [15:0] def_cfg,
    output ebw_pkg::ebw_cfg_t cfg,
    output logic [2:0] win
);
    logic [`EBW_NWIN-1:0] hit;

    // One compare per window; size code widens the window by powers of two
    genvar i;
    generate
        for (i = 0; i < `EBW_NWIN; i = i + 1) begin : g_win
            wire [15:0] sel = sel_flat[i*16 +: 16];
            wire [11:0] base = sel[`EBW_SEL_BASE_MSB:`EBW_SEL_BASE_LSB];
            wire [3:0] size = sel[`EBW_SEL_SIZE_MSB:`EBW_SEL_SIZE_LSB];
            wire [11:0] page = addr[`EBW_PAGE_MSB:`EBW_PAGE_LSB];
            wire en = cfg_flat[i*16 + `EBW_CFG_EN_BIT];
            assign hit[i] = en & ((page >> size) == (base >> size));
        end
    endgenerate

    // Fourth over third, second over first, default otherwise
    assign win = hit[3] ? 3'h4 : hit[2] ? 3'h3 : hit[1] ? 3'h2 :
                 hit[0] ? 3'h1 : 3'h0;
    assign cfg = ebw_pkg::ebw_cfg_t'(
        hit[3] ? cfg_flat[63:48] : hit[2] ? cfg_flat[47:32] :
        hit[1] ? cfg_flat[31:16] : hit[0] ? cfg_flat[15:0] :
        def_cfg);
endmodule

// ==== testbench/ebw_ctrl_properties.sv ====
// Concurrent checks on the ports of the external bus unit
`timescale 1ns/1ps
module ebw_ctrl_properties (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic s_awready,
    input wire logic s_wready,
    input wire logic s_bvalid,
    input wire logic s_bready,
    input wire logic s_arvalid,
    input wire logic s_arready,
    input wire logic s_rvalid,
    input wire logic cpu_req,
    input wire ebw_pkg::ebw_req_t cpu_cmd,
    input wire logic cpu_ack,
    input wire logic cpu_err,
    input wire logic [15:0] port_oe,
    input wire logic ale,
    input wire logic rd_n,
    input wire logic wr_n,
    input wire logic bhe_n,
    input wire logic serial_pins_free,
    input wire logic on_chip_extension_bus_enable,
    input wire logic on_chip_extension_bus_sel
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // Address phase drives the port with both strobes idle
    a_ale_drive: assert property (
        ale |-> port_oe != 16'h0000 && rd_n && wr_n)
        else $error("Address strobe without driven port");
    // Read strobe only after the address phase, port released
    a_rd_release: assert property (
        !rd_n |-> port_oe == 16'h0000 && !ale)
        else $error("Port driven during read strobe");
    // Upper port pins stay undriven while they belong to the serial units
    a_upper_free: assert property (
        serial_pins_free |-> port_oe[15:11] == 5'h00)
        else $error("Upper port pins driven while free");
    a_wr_drive: assert property (!wr_n |-> port_oe != 16'h0000 && rd_n)
        else $error("Write strobe without driven data");
    a_bhe_mode: assert property (!bhe_n |-> !serial_pins_free)
        else $error("High byte enable outside wide mode");
    a_on_chip_extension_bus_gate: assert property (on_chip_extension_bus_sel |-> on_chip_extension_bus_enable)
        else $error("Extension peripheral hit while disabled");
    // Accesses beyond the external space end early with an error
    a_range_err: assert property (
        $rose(cpu_req) && cpu_cmd.addr[23:16] != 8'h00
        |-> ##2 cpu_ack && cpu_err)
        else $error("Out of range access not refused");
    a_ack_bound: assert property ($rose(cpu_req) |-> ##[2:61] cpu_ack)
        else $error("Bus cycle did not finish in time");
    a_ack_pulse: assert property (cpu_ack |=> !cpu_ack)
        else $error("Access acknowledge longer than one cycle");
    // Register slave handshakes
    a_write_resp: assert property (s_awready |-> s_wready && s_bvalid)
        else $error("Write channels not taken together");
    a_b_hold: assert property (s_bvalid && !s_bready |=> s_bvalid)
        else $error("Write response dropped early");
    a_read_resp: assert property (
        s_arvalid && !s_arready && !s_rvalid |=> s_arready && s_rvalid)
        else $error("Read answer late");
    c_ext_cycle: cover property ($rose(ale));
    c_on_chip_extension_bus_hit: cover property (on_chip_extension_bus_sel);
    c_err_ack: cover property (cpu_ack && cpu_err);
endmodule

// ==== testbench/ebw_ext_mem.sv ====
// Byte memory standing on the multiplexed address/data port
`timescale 1ns/1ps
module ebw_ext_mem (
    input wire logic aclk,
    input wire logic [15:0] port_o,
    input wire logic ale,
    input wire logic rd_n,
    input wire logic wr_n,
    input wire logic bhe_n,
    output logic [15:0] port_i
);
    logic [7:0] mem [0:65535];
    logic [15:0] a = 16'h0000;
    logic [15:0] held = 16'h0000;
    wire [15:0] a_hi = a | 16'h0001;
    // Latch address during strobe, capture write data on the same pins
    always @(posedge aclk) begin
        if (ale) a <= port_o;
        if (!rd_n) held <= port_i;
        if (!wr_n && (!a[0] || bhe_n)) mem[a] <= port_o[7:0];
        if (!wr_n && !bhe_n) mem[a_hi] <= port_o[15:8];
    end
    // Released port shows the inverse of the last value read
    assign port_i = rd_n ? ~held : (a[0] ? {mem[a], mem[a]} :
        {mem[a_hi], mem[a]});
endmodule

// ==== testbench/ebw_ctrl_tb.sv ====
// Bench for the external bus unit: registers, windows and bus cycles
`timescale 1ns/1ps
`include "ebw_defs.svh"
module ebw_ctrl_tb;
    logic aclk, aresetn, s_awvalid, s_awready, s_wvalid, s_wready;
    logic s_bvalid, s_bready, s_arvalid, s_arready, s_rvalid, s_rready;
    logic [7:0] s_awaddr, s_araddr;
    logic [31:0] s_wdata, s_rdata, rdat;
    logic [3:0] s_wstrb;
    logic [1:0] s_bresp, s_rresp, brsp, rrsp;
    logic cpu_req, cpu_ack, cpu_err, ale, rd_n, wr_n, bhe_n;
    ebw_pkg::ebw_req_t cpu_cmd;
    logic [15:0] cpu_rdata, port_i, port_o, port_oe;
    logic serial_pins_free, on_chip_extension_bus_enable, on_chip_extension_bus_sel, saw_ale, saw_xsel;
    int n_fail = 0, total_checks = 0, cyc = 0, lat;
    ebw_ctrl dut (.aclk, .aresetn, .s_awaddr, .s_awvalid, .s_awready,
        .s_wdata, .s_wstrb, .s_wvalid, .s_wready, .s_bresp, .s_bvalid,
        .s_bready, .s_araddr, .s_arvalid, .s_arready, .s_rdata, .s_rresp,
        .s_rvalid, .s_rready, .cpu_req, .cpu_cmd, .cpu_ack, .cpu_err,
        .cpu_rdata, .port_i, .port_o, .port_oe, .ale, .rd_n, .wr_n,
        .bhe_n, .serial_pins_free, .on_chip_extension_bus_enable, .on_chip_extension_bus_sel);
    ebw_ext_mem u_mem (.aclk, .port_o, .ale, .rd_n, .wr_n, .bhe_n, .port_i);
    initial begin
        aclk = 1'b0;
        forever #20 aclk = ~aclk;
    end
    task chk(input string nm, input logic [31:0] seen, exp);
        total_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task tally_and_finish;
        $display("Checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    // Register write: both channels offered together, response afterwards
    task axi_wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge aclk);
        s_awaddr <= a;
        s_wdata <= {16'h0000, d};
        s_wstrb <= 4'hf;
        s_awvalid <= 1'b1;
        s_wvalid <= 1'b1;
        do @(posedge aclk); while (s_awready !== 1'b1);
        s_awvalid <= 1'b0;
        s_wvalid <= 1'b0;
        s_bready <= 1'b1;
        do @(posedge aclk); while (s_bvalid !== 1'b1);
        s_bready <= 1'b0;
        brsp = s_bresp;
    endtask
    task axi_rd(input logic [7:0] a);
        @(posedge aclk);
        s_araddr <= a;
        s_arvalid <= 1'b1;
        s_rready <= 1'b1;
        do @(posedge aclk); while (s_arready !== 1'b1);
        s_arvalid <= 1'b0;
        while (s_rvalid !== 1'b1) @(posedge aclk);
        s_rready <= 0;
        rdat = s_rdata;
        rrsp = s_rresp;
    endtask
    // One access from the core side; lat counts cycles to acknowledge
    task cpu(input logic [23:0] a, input logic we, w, input logic [15:0] d);
        @(posedge aclk);
        cpu_cmd <= '{a, we, w, d};
        cpu_req <= 1'b1;
        saw_ale = 1'b0;
        saw_xsel = 1'b0;
        lat = 0;
        do begin
            @(posedge aclk);
            #1 lat++;
        end while (cpu_ack !== 1'b1);
        @(posedge aclk) cpu_req <= 1'b0;
    endtask
    task t_reset;
        chk("pins_free", serial_pins_free, 1);
        chk("on_chip_extension_bus_en", on_chip_extension_bus_enable, 0);
        axi_rd(8'h04);
        chk("def_cfg", rdat, {16'h0000, `EBW_DEFCFG_RST});
        axi_rd(8'h00);
        chk("sys_cfg", rdat, 0);
        axi_rd(8'h2c);
        chk("rresp", rrsp, `EBW_RESP_SLVERR);
        axi_wr(8'h2c, 16'h1234);
        chk("bresp", brsp, `EBW_RESP_SLVERR);
    endtask
    task t_single;
        cpu(24'h001000, 1'b0, 1'b1, 16'h0000);
        chk("err", cpu_err, 1);
        chk("lat", lat, 2);
        chk("ale", saw_ale, 0);
    endtask
    task t_mux16;
        axi_wr(8'h00, 16'h0001);
        repeat (2) @(posedge aclk);
        chk("pins_free", serial_pins_free, 0);
        cpu(24'h001234, 1'b1, 1'b1, 16'hbeef);
        chk("lat", lat, 25);
        cpu(24'h001234, 1'b0, 1'b1, 16'h0000);
        chk("rd16", cpu_rdata, 16'hbeef);
        chk("ale", saw_ale, 1);
        cpu(24'h001235, 1'b0, 1'b0, 16'h0000);
        chk("rd_odd", cpu_rdata[7:0], 8'hbe);
        cpu(24'h001235, 1'b1, 1'b0, 16'h5a5a);
        cpu(24'h001234, 1'b0, 1'b1, 16'h0000);
        chk("wr_odd", cpu_rdata, 16'h5aef);
        cpu(24'h010000, 1'b0, 1'b1, 16'h0000);
        chk("err64k", cpu_err, 1);
        chk("lat64k", lat, 2);
    endtask
    task t_windows;
        logic [15:0] wc [4] = '{16'h0102, 16'h0105, 16'h0101, 16'h0107};
        logic [15:0] ws [4] = '{16'h0010, 16'h0010, 16'h0020, 16'h0020};
        logic [15:0] dc [4] = '{16'h00ff, 16'h0070, 16'h0080, 16'h0000};
        int el [4] = '{25, 9, 6, 5};
        for (int i = 0; i < 4; i++) begin
            axi_wr(8'(8 + 4 * i), wc[i]);
            axi_wr(8'(24 + 4 * i), ws[i]);
        end
        cpu(24'h001000, 1'b0, 1'b1, 16'h0000);
        chk("lat_w2", lat, 10);
        cpu(24'h002000, 1'b0, 1'b1, 16'h0000);
        chk("lat_w4", lat, 12);
        for (int i = 0; i < 4; i++) begin
            axi_wr(8'h04, dc[i]);
            cpu(24'h003000, 1'b0, 1'b1, 16'h0000);
            chk("lat_def", lat, el[i]);
        end
    endtask
    task t_mux8;
        axi_wr(8'h00, 16'h0002);
        repeat (2) @(posedge aclk);
        chk("pins_free", serial_pins_free, 1);
        cpu(24'h000100, 1'b1, 1'b1, 16'ha55a);
        cpu(24'h000100, 1'b0, 1'b1, 16'h0000);
        chk("rd8", cpu_rdata, 16'ha55a);
        chk("lat8", lat, 8);
        cpu(24'h000101, 1'b0, 1'b0, 16'h0000);
        chk("rdb8", cpu_rdata[7:0], 8'ha5);
    endtask
    task t_on_chip_extension_bus;
        axi_wr(8'h00, 16'h0005);
        repeat (2) @(posedge aclk);
        chk("on_chip_extension_bus_en", on_chip_extension_bus_enable, 1);
        cpu(24'h00ef00, 1'b0, 1'b1, 16'h0000);
        chk("xsel_on", saw_xsel, 1);
        chk("ale_on", saw_ale, 0);
        axi_wr(8'h00, 16'h0001);
        cpu(24'h00ef00, 1'b0, 1'b1, 16'h0000);
        chk("xsel_off", saw_xsel, 0);
        chk("ale_off", saw_ale, 1);
    endtask
    // Records strobes seen during each core access
    always @(posedge aclk) begin
        if (ale) saw_ale <= 1'b1;
        if (on_chip_extension_bus_sel) saw_xsel <= 1'b1;
    end
    // Cuts a hang short
    always @(posedge aclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_fail++;
            tally_and_finish;
        end
    end
    initial begin
        aresetn = 1'b0;
        {s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready} = '0;
        {s_awaddr, s_araddr, s_wdata, s_wstrb, cpu_req} = '0;
        cpu_cmd = '0;
        saw_ale = 1'b0;
        saw_xsel = 1'b0;
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        t_reset;
        t_single;
        t_mux16;
        t_windows;
        t_mux8;
        t_on_chip_extension_bus;
        tally_and_finish;
    end
endmodule
bind ebw_ctrl ebw_ctrl_properties u_props (.aclk, .aresetn, .s_awready,
    .s_wready, .s_bvalid, .s_bready, .s_arvalid, .s_arready, .s_rvalid,
    .cpu_req, .cpu_cmd, .cpu_ack, .cpu_err, .port_oe, .ale, .rd_n, .wr_n,
    .bhe_n, .serial_pins_free, .on_chip_extension_bus_enable, .on_chip_extension_bus_sel);
